//--- rtl/coupler_pkg.sv
// shared constants and carrier types for the card coupler config/status block
package coupler_pkg;
    // reference clock rate and filter time
    localparam int unsigned CLOCK_HZ = 50_000_000;
    localparam int unsigned DETECT_FILTER_US = 150;
    localparam int unsigned DETECT_FILTER_CYCLES = (DETECT_FILTER_US * (CLOCK_HZ / 1_000_000)) + 1;

    // card clock divide codes
    localparam logic [1:0] DIV_BY_1 = 2'h0;
    localparam logic [1:0] DIV_BY_2 = 2'h1;
    localparam logic [1:0] DIV_BY_4 = 2'h2;
    localparam logic [1:0] DIV_BY_8 = 2'h3;

    // clock stop/start codes
    localparam logic [1:0] CLK_RUN = 2'h0;
    localparam logic [1:0] CLK_STOP_LOW = 2'h1;
    localparam logic [1:0] CLK_STOP_HIGH = 2'h2;
    localparam logic [1:0] CLK_RESERVED = 2'h3;

    // status select codes
    localparam logic [1:0] STAT_PRESENT = 2'h0;
    localparam logic [1:0] STAT_CONVERTER = 2'h1;
    localparam logic [1:0] STAT_BATTERY = 2'h2;
    localparam logic [1:0] STAT_SUPPLY = 2'h3;

    // power-up settings
    localparam logic RST_SUPPLY_5V = 1'b0;
    localparam logic [1:0] RST_DIVIDE = DIV_BY_1;
    localparam logic [1:0] RST_CLK_MODE = CLK_RUN;
    localparam logic RST_DETECT_NC = 1'b0;

    // latched configuration
    typedef struct packed {
        logic supply_5v;
        logic [1:0] divide;
        logic [1:0] clk_mode;
        logic detect_nc;
    } config_t;

    localparam config_t RESET_CONFIG = '{
        supply_5v: RST_SUPPLY_5V,
        divide: RST_DIVIDE,
        clk_mode: RST_CLK_MODE,
        detect_nc: RST_DETECT_NC
    };

    // analog condition inputs
    typedef struct packed {
        logic converter_ok;
        logic battery_low;
        logic supply_ok;
    } analog_t;
endpackage : coupler_pkg

//--- rtl/card_clock_gen.sv
// glitch-free card clock divider with stop high/low
module card_clock_gen
    import coupler_pkg::*;
(
    // clock and reset
    input wire logic clock_in,
    input wire logic rst_in,
    // settings
    input wire logic enable_in,
    input wire logic [1:0] divide_in,
    input wire logic [1:0] clk_mode_in,
    // card clock
    output logic card_clock_out
);
    logic [2:0] count;
    logic [2:0] next_count;
    logic clk_q;
    logic next_clk_q;
    logic [1:0] divide;
    logic [1:0] next_divide;
    logic [2:0] half;

    // half period in reference cycles minus one; ratio 1 toggles each edge
    always_comb begin
        case (divide)
            DIV_BY_1: half = 3'h0;
            DIV_BY_2: half = 3'h0;
            DIV_BY_4: half = 3'h1;
            default: half = 3'h3;
        endcase
    end

    // settings change only at a falling card edge or while the card clock is held low, so no runt pulse
    always_comb begin
        next_count = count;
        next_clk_q = clk_q;
        next_divide = divide;
        if (!enable_in) begin
            next_clk_q = 1'b0;
            next_count = 3'h0;
            next_divide = divide_in;
        end else if (clk_mode_in == CLK_STOP_LOW && !clk_q) begin
            next_count = 3'h0;
            next_divide = divide_in;
        end else if (clk_mode_in == CLK_STOP_HIGH && clk_q) begin
            next_count = 3'h0;
        end else if (count >= half) begin
            next_count = 3'h0;
            next_clk_q = !clk_q;
            if (clk_q) begin
                next_divide = divide_in;
            end
        end else begin
            next_count = count + 3'h1;
        end
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            count <= 3'h0;
            clk_q <= 1'b0;
            divide <= RST_DIVIDE;
        end else begin
            count <= next_count;
            clk_q <= next_clk_q;
            divide <= next_divide;
        end
    end

    // ratio 1 passes the reference clock gated by a latch-free low-phase enable
    logic pass_en;
    logic next_pass_en;
    always_comb begin
        next_pass_en = enable_in && divide == DIV_BY_1 && clk_mode_in == CLK_RUN;
    end
    always_ff @(negedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            pass_en <= 1'b0;
        end else begin
            pass_en <= next_pass_en;
        end
    end

    assign card_clock_out = pass_en ? clock_in : clk_q;
endmodule : card_clock_gen

//--- rtl/card_coupler_config_status.sv
// configuration latch, status multiplexer and card-detect filter of the coupler
module card_coupler_config_status
    import coupler_pkg::*;
#(
    parameter int unsigned FILTER_CYCLES = DETECT_FILTER_CYCLES
) (
    // clock and reset
    input wire logic clock_in,
    input wire logic rst_in,
    // host interface
    input wire logic chip_select_n_in,
    input wire logic program_select_n_in,
    input wire logic select_bit0_in,
    input wire logic select_bit1_in,
    input wire logic card_power_request_in,
    input wire logic host_data_in,
    input wire logic host_reset_in,
    output logic host_data_out,
    output logic host_data_oe_out,
    output logic status_out,
    output logic event_n_out,
    // card side
    input wire logic card_detect_in,
    input wire logic card_data_in,
    output logic card_data_out,
    output logic card_data_oe_out,
    output logic card_reset_out,
    output logic card_clock_out,
    output logic card_supply_en_out,
    output logic card_supply_5v_out,
    // analog conditions
    input wire analog_t analog_in
);
    // input synchronisers (first stage read only by second)
    logic [2:0] sync_a;
    logic [2:0] sync_b;
    logic [2:0] sync_c;
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            sync_a <= 3'h7;
            sync_b <= 3'h7;
            sync_c <= 3'h7;
        end else begin
            sync_a <= {chip_select_n_in, card_power_request_in, card_detect_in};
            sync_b <= sync_a;
            sync_c <= sync_b;
        end
    end
    logic cs_n;
    logic pwr_req;
    logic det_raw;
    logic cs_rise;
    logic pwr_rise;
    assign cs_n = sync_b[2];
    assign pwr_req = sync_b[1];
    assign det_raw = sync_b[0];
    assign cs_rise = sync_b[2] && !sync_c[2];
    assign pwr_rise = sync_b[1] && !sync_c[1];

    // configuration latch; codes sampled while select low and programming
    config_t cfg;
    config_t next_cfg;
    logic [3:0] code;
    logic [3:0] next_code;
    logic code_valid;
    logic next_code_valid;
    always_comb begin
        next_cfg = cfg;
        next_code = code;
        next_code_valid = code_valid;
        if (!cs_n && !program_select_n_in) begin
            next_code = {host_reset_in, select_bit1_in, select_bit0_in, host_data_in};
            next_code_valid = 1'b1;
        end
        if (cs_rise) begin
            next_code_valid = 1'b0;
            if (code_valid) begin
                if (!code[3]) begin
                    next_cfg.supply_5v = code[2];
                    next_cfg.divide = code[1:0];
                end else if (!code[2]) begin
                    if (code[1:0] != CLK_RESERVED) begin
                        next_cfg.clk_mode = code[1:0];
                    end
                end else begin
                    next_cfg.detect_nc = (code[1:0] != 2'h0);
                end
            end
        end
        if (cs_n && !cs_rise) begin
            next_code_valid = 1'b0;
        end
    end
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            cfg <= RESET_CONFIG;
            code <= 4'h0;
            code_valid <= 1'b0;
        end else begin
            cfg <= next_cfg;
            code <= next_code;
            code_valid <= next_code_valid;
        end
    end

    // card-detect filter; polarity NO (high = card present) unless detect_nc selects NC
    logic det_level;
    logic present;
    logic next_present;
    logic [$clog2(FILTER_CYCLES+1)-1:0] filt_cnt;
    logic [$clog2(FILTER_CYCLES+1)-1:0] next_filt_cnt;
    logic event_n;
    logic next_event_n;
    assign det_level = cfg.detect_nc ? !det_raw : det_raw;
    always_comb begin
        next_present = present;
        next_filt_cnt = filt_cnt;
        next_event_n = event_n;
        if (det_level == present) begin
            next_filt_cnt = '0;
        end else if (filt_cnt >= FILTER_CYCLES[$bits(filt_cnt)-1:0]) begin
            next_present = det_level;
            next_filt_cnt = '0;
        end else begin
            next_filt_cnt = filt_cnt + 1'b1;
        end
        if (cs_rise || (pwr_rise && !cs_n)) begin
            next_event_n = 1'b1;
        end
        // a new detection wins over a simultaneous release
        if (next_present != present) begin
            next_event_n = 1'b0;
        end
    end
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            present <= 1'b0;
            filt_cnt <= '0;
            event_n <= 1'b1;
        end else begin
            present <= next_present;
            filt_cnt <= next_filt_cnt;
            event_n <= next_event_n;
        end
    end

    // power: only with request while selected, dropped when card leaves
    logic powered;
    logic next_powered;
    always_comb begin
        next_powered = !cs_n && pwr_req && present;
    end
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            powered <= 1'b0;
        end else begin
            powered <= next_powered;
        end
    end

    // status multiplexer, registered; held high while programming
    logic status;
    logic next_status;
    always_comb begin
        next_status = status;
        if (!cs_n && !program_select_n_in) begin
            next_status = 1'b1;
        end else if (!cs_n) begin
            case ({select_bit1_in, select_bit0_in})
                STAT_PRESENT: next_status = present;
                STAT_CONVERTER: next_status = analog_in.converter_ok;
                STAT_BATTERY: next_status = analog_in.battery_low;
                STAT_SUPPLY: next_status = analog_in.supply_ok && powered;
                default: next_status = 1'b0;
            endcase
        end
    end
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            status <= 1'b1;
        end else begin
            status <= next_status;
        end
    end

    // card pin pass-through, blocked while programming or unpowered
    logic pass;
    logic card_rst;
    logic card_dat;
    logic card_dat_oe;
    logic host_dat;
    logic next_card_rst;
    logic next_card_dat;
    logic next_card_dat_oe;
    logic next_host_dat;
    always_comb begin
        pass = powered && program_select_n_in;
        next_card_rst = pass ? host_reset_in : 1'b0;
        next_card_dat = pass ? host_data_in : 1'b0;
        next_card_dat_oe = !pass || !host_data_in;
        next_host_dat = card_data_in;
    end
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            card_rst <= 1'b0;
            card_dat <= 1'b0;
            card_dat_oe <= 1'b1;
            host_dat <= 1'b1;
        end else begin
            card_rst <= next_card_rst;
            card_dat <= next_card_dat;
            card_dat_oe <= next_card_dat_oe;
            host_dat <= next_host_dat;
        end
    end

    card_clock_gen u_clock (
        .clock_in(clock_in),
        .rst_in(rst_in),
        .enable_in(powered),
        .divide_in(cfg.divide),
        .clk_mode_in(cfg.clk_mode),
        .card_clock_out(card_clock_out)
    );

    assign status_out = status;
    assign event_n_out = event_n;
    assign card_reset_out = card_rst;
    assign card_data_out = card_dat;
    assign card_data_oe_out = card_dat_oe;
    assign host_data_out = host_dat;
    // open-drain style: drive host line only low when passing card data
    assign host_data_oe_out = powered && program_select_n_in && !cs_n && !host_dat;
    assign card_supply_en_out = powered;
    assign card_supply_5v_out = cfg.supply_5v;

    // checks
    chk_status_prog: assert property (@(posedge clock_in) disable iff (rst_in)
        (!cs_n && !program_select_n_in) |=> status_out)
        else $error("status not high while programming");
    chk_supply_gate: assert property (@(posedge clock_in) disable iff (rst_in)
        card_supply_en_out |-> $past(!cs_n && pwr_req))
        else $error("supply on without request");
    chk_standby_low: assert property (@(posedge clock_in) disable iff (rst_in)
        (cs_n [*3]) |-> (!card_supply_en_out && !card_reset_out && !card_data_out))
        else $error("card lines not low in standby");
    chk_event_release: assert property (@(posedge clock_in) disable iff (rst_in)
        (cs_rise && present == next_present) |=> event_n_out)
        else $error("event not released");
    chk_event_filter: assert property (@(posedge clock_in) disable iff (rst_in)
        $fell(event_n_out) |-> $changed(present))
        else $error("event without filtered change");
    chk_cfg_stable: assert property (@(posedge clock_in) disable iff (rst_in)
        !cs_rise |=> $stable(cfg))
        else $error("settings changed without latch");
    chk_status_battery: assert property (@(posedge clock_in) disable iff (rst_in)
        (!cs_n && program_select_n_in && select_bit1_in && !select_bit0_in)
        |=> status_out == $past(analog_in.battery_low))
        else $error("battery status wrong");
    chk_pass_block: assert property (@(posedge clock_in) disable iff (rst_in)
        !program_select_n_in |=> !card_reset_out)
        else $error("reset passed while programming");

    cov_latch: cover property (@(posedge clock_in) cs_rise && code_valid);
    cov_event: cover property (@(posedge clock_in) $fell(event_n_out));
    cov_power: cover property (@(posedge clock_in) $rose(card_supply_en_out));
endmodule : card_coupler_config_status

//--- verif/host_model.sv
// host controller model driving the coupler's parallel pins
module host_model (
    // clock and status
    input wire logic clock_in,
    input wire logic status_in,
    // host pins
    output logic chip_select_n_out,
    output logic program_select_n_out,
    output logic [1:0] select_bits_out,
    output logic card_power_request_out,
    output logic host_data_out,
    output logic host_reset_out
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        chip_select_n_out = 1'b1;
        program_select_n_out = 1'b1;
        select_bits_out = 2'h0;
        card_power_request_out = 1'b0;
        host_data_out = 1'b1;
        host_reset_out = 1'b0;
    end

    // pins move only after a falling edge, away from the sampling edge
    task automatic drive(input logic cs_n, input logic pgm_n, input logic pwr,
                         input logic [1:0] sel);
        @(negedge clock_in);
        chip_select_n_out = cs_n;
        program_select_n_out = pgm_n;
        card_power_request_out = pwr;
        select_bits_out = sel;
    endtask : drive

    // code is {reset, bit1, bit0, data}; hold sets how slow the host is
    task automatic program_code(input logic [3:0] code, input int hold, output logic seen);
        // release select first, then change program select with select high
        drive(1'b1, program_select_n_out, card_power_request_out, code[2:1]);
        drive(1'b1, 1'b0, card_power_request_out, code[2:1]);
        host_reset_out = code[3];
        host_data_out = code[0];
        drive(1'b0, 1'b0, card_power_request_out, code[2:1]);
        repeat (hold) @(negedge clock_in);
        seen = status_in;
        chip_select_n_out = 1'b1;
        // sync plus latch needs three edges before the setting shows
        repeat (4) @(negedge clock_in);
    endtask : program_code

    task automatic read_status(input logic [1:0] sel, output logic seen);
        drive(chip_select_n_out, 1'b1, card_power_request_out, sel);
        drive(1'b0, 1'b1, card_power_request_out, sel);
        repeat (3) @(negedge clock_in);
        seen = status_in;
    endtask : read_status
endmodule : host_model

//--- verif/card_coupler_config_status_tb.sv
// self-checking bench for the coupler config/status block
module card_coupler_config_status_tb;
    import coupler_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;

    localparam int FILT = 10;
    logic clock_in, rst_in, cs_n, pgm_n, pwr, hdata, hreset, card_detect, card_data, st;
    logic [1:0] sel;
    analog_t analog;
    logic host_data_out, host_data_oe_out, status_out, event_n_out, card_data_out;
    logic card_data_oe_out, card_reset_out, card_clock_out, card_supply_en_out;
    logic card_supply_5v_out;
    int err_total = 0;
    int checks_done = 0;
    int cycles = 0;
    int clk_edges = 0;
    int runts = 0;
    realtime rise_t = 0.0;

    host_model host (.clock_in(clock_in), .status_in(status_out),
        .chip_select_n_out(cs_n), .program_select_n_out(pgm_n), .select_bits_out(sel),
        .card_power_request_out(pwr), .host_data_out(hdata), .host_reset_out(hreset));

    card_coupler_config_status #(.FILTER_CYCLES(FILT)) dut (.clock_in(clock_in),
        .rst_in(rst_in), .chip_select_n_in(cs_n), .program_select_n_in(pgm_n),
        .select_bit0_in(sel[0]), .select_bit1_in(sel[1]), .card_power_request_in(pwr),
        .host_data_in(hdata), .host_reset_in(hreset), .host_data_out(host_data_out),
        .host_data_oe_out(host_data_oe_out), .status_out(status_out),
        .event_n_out(event_n_out), .card_detect_in(card_detect), .card_data_in(card_data),
        .card_data_out(card_data_out), .card_data_oe_out(card_data_oe_out),
        .card_reset_out(card_reset_out), .card_clock_out(card_clock_out),
        .card_supply_en_out(card_supply_en_out), .card_supply_5v_out(card_supply_5v_out),
        .analog_in(analog));

    initial begin
        clock_in = 1'b0;
        forever #10 clock_in = ~clock_in;
    end

    always @(posedge clock_in) begin
        cycles++;
        if (cycles == 5000) begin
            err_total++;
            results();
        end
    end

    // a high pulse shorter than 9 ns, just under half a reference period, is a runt
    always @(posedge card_clock_out) begin
        clk_edges++;
        rise_t = $realtime;
    end
    always @(negedge card_clock_out) begin
        if (rise_t > 0.0 && $realtime - rise_t < 9.0) runts++;
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check

    task automatic results();
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : results

    task automatic event_delay(output int n);
        n = 0;
        while (event_n_out !== 1'b0 && n < 3 * FILT) begin
            @(negedge clock_in);
            n++;
        end
    endtask : event_delay

    // powers the card and counts card clock rising edges over 64 cycles
    task automatic measure(input int exp);
        int n;
        host.drive(host.chip_select_n_out, 1'b1, 1'b1, 2'h0);
        host.drive(1'b0, 1'b1, 1'b1, 2'h0);
        repeat (20) @(negedge clock_in);
        n = clk_edges;
        repeat (64) @(negedge clock_in);
        n = clk_edges - n;
        check("card clock edges", n + 1 >= exp && n <= exp + 1, 1);
    endtask : measure

    task automatic t_defaults();
        check("supply 5v", card_supply_5v_out, 0);
        check("supply enable", card_supply_en_out, 0);
        check("card clock", card_clock_out, 0);
        check("card reset", card_reset_out, 0);
        check("card data", card_data_out, 0);
    endtask : t_defaults

    task automatic t_event();
        int n;
        host.program_code(4'h8, 3, st);
        @(negedge clock_in);
        card_detect = 1'b1;
        repeat (FILT - 3) @(negedge clock_in);
        card_detect = 1'b0;
        repeat (FILT + 6) @(negedge clock_in);
        check("event short pulse", event_n_out, 1);
        card_detect = 1'b1;
        event_delay(n);
        check("event delay", n >= FILT && n <= FILT + 6, 1);
        host.read_status(STAT_PRESENT, st);
        check("present", st, 1);
        check("event held", event_n_out, 0);
        host.drive(1'b1, 1'b1, 1'b0, 2'h0);
        repeat (4) @(negedge clock_in);
        check("event cleared by select", event_n_out, 1);
    endtask : t_event

    task automatic t_power();
        int n;
        host.drive(1'b0, 1'b1, 1'b0, 2'h0);
        repeat (6) @(negedge clock_in);
        check("supply without request", card_supply_en_out, 0);
        measure(64);
        check("supply with request", card_supply_en_out, 1);
        host.drive(1'b1, 1'b1, 1'b1, 2'h0);
        repeat (6) @(negedge clock_in);
        check("standby supply", card_supply_en_out, 0);
        check("standby clock", card_clock_out, 0);
        card_detect = 1'b0;
        event_delay(n);
        check("standby extraction", event_n_out, 0);
        host.drive(1'b0, 1'b1, 1'b0, 2'h0);
        repeat (6) @(negedge clock_in);
        check("event kept on select", event_n_out, 0);
        host.drive(1'b0, 1'b1, 1'b1, 2'h0);
        repeat (6) @(negedge clock_in);
        check("event cleared by request", event_n_out, 1);
        check("no card no supply", card_supply_en_out, 0);
        card_detect = 1'b1;
        event_delay(n);
    endtask : t_power

    task automatic t_supply();
        analog = 3'b011;
        host.read_status(STAT_CONVERTER, st);
        check("converter fault", st, 0);
        host.program_code(4'h4, 3, st);
        check("status in programming", st, 1);
        check("5v", card_supply_5v_out, 1);
        host.read_status(STAT_CONVERTER, st);
        check("status kept", st, 0);
        host.program_code(4'h8, 6, st);
        check("5v after clock code", card_supply_5v_out, 1);
        host.program_code(4'hC, 3, st);
        check("5v after detect code", card_supply_5v_out, 1);
        host.program_code(4'h0, 3, st);
        check("3v", card_supply_5v_out, 0);
    endtask : t_supply

    task automatic t_clock();
        for (int d = 0; d < 4; d++) begin
            host.program_code({2'b00, d[1:0]}, 3, st);
            measure(64 >> d);
        end
        host.program_code(4'h9, 3, st);
        measure(0);
        check("stop low", card_clock_out, 0);
        host.program_code(4'hA, 3, st);
        measure(0);
        check("stop high", card_clock_out, 1);
        host.program_code(4'hB, 3, st);
        measure(0);
        check("reserved ignored", card_clock_out, 1);
        host.program_code(4'h8, 3, st);
        measure(8);
    endtask : t_clock

    task automatic t_status();
        for (int a = 0; a < 8; a++) begin
            analog = a[2:0];
            for (int s = 0; s < 4; s++) begin
                host.read_status(s[1:0], st);
                check("status select", st, s == 0 ? 1 : a[3 - s]);
            end
        end
    endtask : t_status

    task automatic t_polarity();
        logic [3:0] codes [4] = '{4'hD, 4'hE, 4'hF, 4'hC};
        for (int i = 0; i < 4; i++) begin
            host.program_code(codes[i], 3, st);
            host.drive(1'b1, 1'b1, 1'b1, 2'h0);
            host.drive(1'b0, 1'b1, 1'b1, 2'h0);
            repeat (FILT + 8) @(negedge clock_in);
            host.read_status(STAT_PRESENT, st);
            check("detect polarity", st, codes[i] == 4'hC);
        end
    endtask : t_polarity

    task automatic t_pass();
        @(negedge clock_in);
        host.host_reset_out = 1'b1;
        host.host_data_out = 1'b0;
        card_data = 1'b0;
        repeat (4) @(negedge clock_in);
        check("card reset level", card_reset_out, 1);
        check("card data level", card_data_out, 0);
        check("card data drive", card_data_oe_out, 1);
        check("host data level", host_data_out, 0);
        check("host data drive", host_data_oe_out, 1);
        host.host_reset_out = 1'b0;
        host.host_data_out = 1'b1;
        card_data = 1'b1;
        repeat (4) @(negedge clock_in);
        check("card reset low", card_reset_out, 0);
        check("card data released", card_data_oe_out, 0);
        check("host data high", host_data_out, 1);
        check("host data released", host_data_oe_out, 0);
    endtask : t_pass

    initial begin
        rst_in = 1'b1;
        card_detect = 1'b0;
        card_data = 1'b1;
        analog = 3'b101;
        repeat (6) @(negedge clock_in);
        rst_in = 1'b0;
        repeat (3) @(negedge clock_in);
        t_defaults();
        t_event();
        t_power();
        t_supply();
        t_clock();
        t_status();
        t_polarity();
        t_pass();
        check("runt pulses", runts, 0);
        results();
    end
endmodule : card_coupler_config_status_tb
